// File: pics_pkg.sv
// constants and types for the phy interrupt, counter and pcs config bank
package pics_pkg;

    localparam logic [7:0] OFF_IRQ_CONTROL = 8'hC4;
    localparam logic [7:0] OFF_IRQ_STATUS  = 8'hC8;
    localparam logic [7:0] OFF_FALSE_CARR  = 8'hD0;
    localparam logic [7:0] OFF_RX_ERROR    = 8'hD4;
    localparam logic [7:0] OFF_PCS_CONFIG  = 8'hD8;

    localparam logic [15:0] RST_IRQ_CONTROL = 16'h0000;
    localparam logic [15:0] RST_IRQ_STATUS  = 16'h0000;
    localparam logic [7:0]  RST_COUNTER     = 8'h00;
    localparam logic [15:0] RST_PCS_CONFIG  = 16'h0100;

    // control register fields
    localparam int BIT_TEST_IRQ   = 0;
    localparam int BIT_EVENT_EN   = 1;
    // status/mask register fields
    localparam int BIT_PENDING    = 15;
    localparam int MASK_LO        = 9;
    localparam int MASK_HI        = 14;
    localparam int NUM_EVENTS     = 6;
    // pcs config fields
    localparam int BIT_NRZI_BYP   = 2;
    localparam int BIT_FORCE_100  = 5;
    localparam int BIT_SD_ALGO    = 8;
    localparam int BIT_SD_FORCE   = 9;
    localparam int BIT_TRUE_QUIET = 10;
    localparam int BIT_FREE_CLK   = 11;
    localparam int BIT_BLOCK_BYP  = 12;
    // writable bits per register
    localparam logic [15:0] WMASK_IRQ_CONTROL = 16'h0003;
    localparam logic [15:0] WMASK_IRQ_STATUS  = 16'h7E00;
    localparam logic [15:0] WMASK_PCS_CONFIG  = 16'h1F24;

    localparam logic [7:0] COUNT_MAX  = 8'hFF;
    localparam int         HALF_BIT   = 7;

    // event order matches mask bits 9..14
    localparam int EV_RX_HALF   = 0;
    localparam int EV_FC_HALF   = 1;
    localparam int EV_AUTONEG   = 2;
    localparam int EV_REMOTE    = 3;
    localparam int EV_JABBER    = 4;
    localparam int EV_LINK      = 5;

    typedef struct packed {
        logic [7:0]  addr;
        logic [15:0] wdata;
        logic        wr;
        logic        rd;
    } pics_bus_t;

    typedef struct packed {
        logic block_code_bypass;
        logic free_receive_clock;
        logic true_quiet_enable;
        logic signal_detect_force;
        logic signal_detect_algorithm;
        logic fast_link_force;
        logic nrzi_bypass;
    } pics_pcs_t;

    typedef enum logic [1:0] {
        PICS_IDLE    = 2'b00,
        PICS_CARRIER = 2'b01,
        PICS_COUNTED = 2'b11
    } pics_carrier_t;

endpackage

// File: pics_bank.sv
// phy interrupt control/status, event counters and pcs configuration bank
// How it works
// RQ1 - test bit 0 raises interrupt after each read, ignoring event enable
// RQ2 - with test bit set, one interrupt per completed management read
// RQ3 - control bit 1 enables event interrupts; clear suppresses them
// RQ4 - unmasked event with enable set flags phy bit in host status
// RQ5 - sources: link, jabber, remote fault, autoneg done, counter half-full
// RQ6 - status bit 15 shows pending interrupt, read-only, cleared by its read
// RQ7 - mask bits 14..9 let the matching event interrupt when zero
// RQ8 - control bits 15:2 ignore writes and read zero
// RQ9 - false-carrier count bits 7:0 add one per event, stick at FFh
// RQ10 - false-carrier count resets zero, writable, clears on read
// RQ11 - receive-error count advances at most once per bad carrier
// RQ12 - no receive-error count for a carrier with collision
// RQ13 - receive-error count saturates, writable, clears on read, resets zero
// RQ14 - each counter reaching half range gives a maskable event
// RQ15 - half-full means count msb set, 0x80 or above
// RQ16 - pcs bit 12 bypasses 4b/5b coding
// RQ17 - pcs bit 11 makes receive clock free-running
// RQ18 - pcs bit 10 selects true quiet transmit
// RQ19 - pcs bit 9 forces signal detect active
// RQ20 - pcs bit 8 selects enhanced detect; reset value 0100h
// RQ21 - pcs bit 5 forces 100 link, ored with mac force input
// RQ22 - pcs bit 2 bypasses nrzi coding
`timescale 1ns/1ns
`default_nettype none
module pics_bank (
    input  wire logic              clk,
    input  wire logic              rst_n,
    input  wire logic [7:0]        reg_addr,
    input  wire logic [15:0]       reg_wdata,
    input  wire logic              reg_wr,
    input  wire logic              reg_rd,
    output var  logic [15:0]       reg_rdata,
    input  wire logic              link_change,
    input  wire logic              jabber_event,
    input  wire logic              remote_fault,
    input  wire logic              autoneg_done,
    input  wire logic              false_carrier,
    input  wire logic              carrier_valid,
    input  wire logic              symbol_error,
    input  wire logic              collision,
    input  wire logic              mac_fast_link_force,
    output var  logic              host_irq_status,
    output var  pics_pkg::pics_pcs_t pcs_ctrl
);

    pics_pkg::pics_bus_t bus;
    assign bus = '{addr: reg_addr, wdata: reg_wdata, wr: reg_wr, rd: reg_rd};

    logic [15:0] phy_irq_control;
    logic [15:0] mask_bits;
    logic        phy_irq_pending;
    logic [7:0]  false_carrier_count;
    logic [7:0]  receive_error_count;
    logic [15:0] pcs_config_status;
    logic [5:0]  prev_half;
    logic        prev_link;
    logic        prev_jab;
    logic        prev_rf;
    logic        prev_anc;
    logic        carrier_bad;
    logic        carrier_col;
    pics_pkg::pics_carrier_t carrier_state;
    pics_pkg::pics_carrier_t next_carrier_state;

    // address decode
    wire sel_ctl = bus.addr == pics_pkg::OFF_IRQ_CONTROL;
    wire sel_sts = bus.addr == pics_pkg::OFF_IRQ_STATUS;
    wire sel_fc  = bus.addr == pics_pkg::OFF_FALSE_CARR;
    wire sel_re  = bus.addr == pics_pkg::OFF_RX_ERROR;
    wire sel_pcs = bus.addr == pics_pkg::OFF_PCS_CONFIG;

    wire wr_ctl = bus.wr && sel_ctl;
    wire wr_sts = bus.wr && sel_sts;
    wire wr_fc  = bus.wr && sel_fc;
    wire wr_re  = bus.wr && sel_re;
    wire wr_pcs = bus.wr && sel_pcs;
    wire rd_sts = bus.rd && sel_sts;
    wire rd_fc  = bus.rd && sel_fc;
    wire rd_re  = bus.rd && sel_re;

    wire test_force = phy_irq_control[pics_pkg::BIT_TEST_IRQ];
    wire event_en   = phy_irq_control[pics_pkg::BIT_EVENT_EN];

    // events are rising edges of level inputs, either edge for link change
    wire fc_half = false_carrier_count[pics_pkg::HALF_BIT]; // [RQ15]
    wire re_half = receive_error_count[pics_pkg::HALF_BIT]; // [RQ15]
    wire [5:0] half_now = {4'h0, fc_half, re_half};
    wire [5:0] raw_levels = {link_change, jabber_event, remote_fault,
                             autoneg_done, 2'b00};
    wire [5:0] prev_levels = {prev_link, prev_jab, prev_rf, prev_anc,
                              2'b00};
    wire [5:0] half_rise = half_now & ~prev_half; // [RQ14]
    wire [5:0] event_vec;
    wire [5:0] unmasked;

    genvar gi;
    generate
        for (gi = 0; gi < pics_pkg::NUM_EVENTS; gi = gi + 1) begin : g_ev
            // link change is itself a change, the others fire on onset
            if (gi == pics_pkg::EV_LINK) begin : g_lnk
                assign event_vec[gi] = raw_levels[gi] != prev_levels[gi];
            end else if (gi >= pics_pkg::EV_AUTONEG) begin : g_lvl
                assign event_vec[gi] = raw_levels[gi] & ~prev_levels[gi];
            end else begin : g_half
                assign event_vec[gi] = half_rise[gi];
            end
            // [RQ7]
            assign unmasked[gi] = event_vec[gi]
                                  & ~mask_bits[pics_pkg::MASK_LO + gi];
        end
    endgenerate

    wire any_event = event_en && (|unmasked); // [RQ3] [RQ4] [RQ5]
    // a read of any register completes a management read
    wire any_read  = bus.rd;
    wire test_hit  = test_force && any_read; // [RQ1] [RQ2]
    wire set_pend  = any_event || test_hit;

    // carrier event tracking for the receive-error counter
    wire carrier_end = !carrier_valid;
    wire count_carrier = carrier_state == pics_pkg::PICS_CARRIER
                         && carrier_end && carrier_bad && !carrier_col;

    always_comb begin
        next_carrier_state = carrier_state;
        case (carrier_state)
            pics_pkg::PICS_IDLE: begin
                if (carrier_valid) begin
                    next_carrier_state = pics_pkg::PICS_CARRIER;
                end
            end
            pics_pkg::PICS_CARRIER: begin
                if (carrier_end) begin
                    next_carrier_state = pics_pkg::PICS_IDLE;
                end
            end
            pics_pkg::PICS_COUNTED: begin
                next_carrier_state = pics_pkg::PICS_IDLE;
            end
            default: begin
                next_carrier_state = pics_pkg::PICS_IDLE;
            end
        endcase
    end

    wire bad_now = carrier_valid && symbol_error;
    wire col_now = carrier_valid && collision;

    // counters: write loads, read clears, increment adds on top of both unless the old count or the loaded value is FFh
    wire fc_inc = false_carrier
                  && (false_carrier_count != pics_pkg::COUNT_MAX);
    wire re_inc = count_carrier
                  && (receive_error_count != pics_pkg::COUNT_MAX);
    wire [7:0] fc_base = wr_fc ? bus.wdata[7:0]
                       : (rd_fc ? pics_pkg::RST_COUNTER
                                : false_carrier_count);
    wire [7:0] re_base = wr_re ? bus.wdata[7:0]
                       : (rd_re ? pics_pkg::RST_COUNTER
                                : receive_error_count);
    // an event in the clearing cycle counts from zero, but is lost if the old count was FFh
    wire [7:0] next_fc = (fc_inc && fc_base != pics_pkg::COUNT_MAX)
                         ? fc_base + 8'h01 : fc_base; // [RQ9] [RQ10]
    wire [7:0] next_re = (re_inc && re_base != pics_pkg::COUNT_MAX)
                         ? re_base + 8'h01 : re_base; // [RQ11] [RQ13]

    // pending flag: set beats read-clear
    wire next_pend = set_pend ? 1'b1
                   : (rd_sts ? 1'b0 : phy_irq_pending); // [RQ6]

    wire [15:0] status_view = {phy_irq_pending,
                               mask_bits[pics_pkg::MASK_HI:pics_pkg::MASK_LO],
                               9'h000};
    wire [15:0] rdata_mux = sel_ctl ? phy_irq_control
                          : sel_sts ? status_view
                          : sel_fc  ? {8'h00, false_carrier_count}
                          : sel_re  ? {8'h00, receive_error_count}
                          : sel_pcs ? pcs_config_status
                          : 16'h0000;
    wire [15:0] next_rdata = bus.rd ? rdata_mux : 16'h0000;

    wire fast_link = pcs_config_status[pics_pkg::BIT_FORCE_100]
                     || mac_fast_link_force; // [RQ21]
    pics_pkg::pics_pcs_t next_pcs;
    assign next_pcs = '{
        block_code_bypass:       pcs_config_status[pics_pkg::BIT_BLOCK_BYP],
        free_receive_clock:      pcs_config_status[pics_pkg::BIT_FREE_CLK],
        true_quiet_enable:       pcs_config_status[pics_pkg::BIT_TRUE_QUIET],
        signal_detect_force:     pcs_config_status[pics_pkg::BIT_SD_FORCE],
        signal_detect_algorithm: pcs_config_status[pics_pkg::BIT_SD_ALGO],
        fast_link_force:         fast_link,
        nrzi_bypass:             pcs_config_status[pics_pkg::BIT_NRZI_BYP]
    }; // [RQ16] [RQ17] [RQ18] [RQ19] [RQ20] [RQ22]

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            phy_irq_control <= pics_pkg::RST_IRQ_CONTROL;
            mask_bits       <= pics_pkg::RST_IRQ_STATUS;
            pcs_config_status <= pics_pkg::RST_PCS_CONFIG; // [RQ20]
        end else begin
            if (wr_ctl) begin
                phy_irq_control <= bus.wdata
                                   & pics_pkg::WMASK_IRQ_CONTROL; // [RQ8]
            end
            if (wr_sts) begin
                mask_bits <= bus.wdata & pics_pkg::WMASK_IRQ_STATUS;
            end
            if (wr_pcs) begin
                pcs_config_status <= bus.wdata & pics_pkg::WMASK_PCS_CONFIG;
            end
        end
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            false_carrier_count <= pics_pkg::RST_COUNTER;
            receive_error_count <= pics_pkg::RST_COUNTER;
            phy_irq_pending     <= 1'b0;
            host_irq_status     <= 1'b0;
        end else begin
            false_carrier_count <= next_fc;
            receive_error_count <= next_re;
            phy_irq_pending     <= next_pend;
            host_irq_status     <= next_pend; // [RQ4]
        end
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            carrier_state <= pics_pkg::PICS_IDLE;
            carrier_bad   <= 1'b0;
            carrier_col   <= 1'b0;
        end else begin
            carrier_state <= next_carrier_state;
            // flags gather over one carrier, restart when idle
            carrier_bad <= (carrier_state == pics_pkg::PICS_CARRIER)
                           ? (carrier_bad || bad_now) : bad_now; // [RQ11]
            carrier_col <= (carrier_state == pics_pkg::PICS_CARRIER)
                           ? (carrier_col || col_now) : col_now; // [RQ12]
        end
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            prev_half <= 6'h00;
            prev_link <= 1'b0;
            prev_jab  <= 1'b0;
            prev_rf   <= 1'b0;
            prev_anc  <= 1'b0;
        end else begin
            prev_half <= half_now;
            prev_link <= link_change;
            prev_jab  <= jabber_event;
            prev_rf   <= remote_fault;
            prev_anc  <= autoneg_done;
        end
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            reg_rdata <= 16'h0000;
            pcs_ctrl  <= '0;
        end else begin
            reg_rdata <= next_rdata;
            pcs_ctrl  <= next_pcs;
        end
    end

endmodule
`default_nettype wire

// File: pics_bank_asserts.sv
// concurrent checks on the ports of the interrupt, counter and pcs bank
`timescale 1ns/1ns
`default_nettype none
module pics_bank_asserts (
    input wire logic                clk,
    input wire logic                rst_n,
    input wire logic [7:0]          reg_addr,
    input wire logic [15:0]         reg_wdata,
    input wire logic                reg_wr,
    input wire logic                reg_rd,
    input wire logic [15:0]         reg_rdata,
    input wire logic                link_change,
    input wire logic                jabber_event,
    input wire logic                remote_fault,
    input wire logic                autoneg_done,
    input wire logic                false_carrier,
    input wire logic                carrier_valid,
    input wire logic                symbol_error,
    input wire logic                collision,
    input wire logic                mac_fast_link_force,
    input wire logic                host_irq_status,
    input wire pics_pkg::pics_pcs_t pcs_ctrl
);
    logic        test_on;
    logic        ev_en;
    logic [15:0] pcs_shadow;
    wire         rd_stat = reg_rd && reg_addr == 8'hC8;
    wire         wr_pcs  = reg_wr && reg_addr == 8'hD8;
    wire  [15:0] pcs_view = {3'b000, pcs_ctrl.block_code_bypass,
        pcs_ctrl.free_receive_clock, pcs_ctrl.true_quiet_enable,
        pcs_ctrl.signal_detect_force, pcs_ctrl.signal_detect_algorithm,
        5'b00000, pcs_ctrl.nrzi_bypass, 2'b00};

    // only the bits whose output has no second source are shadowed
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            test_on    <= 1'b0;
            ev_en      <= 1'b0;
            pcs_shadow <= 16'h0100;
        end else begin
            if (reg_wr && reg_addr == 8'hC4) begin
                test_on <= reg_wdata[0];
                ev_en   <= reg_wdata[1];
            end
            if (wr_pcs) begin
                pcs_shadow <= reg_wdata & 16'h1F04;
            end
        end
    end

    default clocking cb @(posedge clk); endclocking
    default disable iff (!rst_n);

    ctrl_reserved_a: assert property (reg_rd && reg_addr == 8'hC4
        |=> reg_rdata[15:2] == 14'h0000) else $error("control upper bits set");
    count_upper_a: assert property (reg_rd && reg_addr[7:4] == 4'hD
        && !reg_addr[3] |=> reg_rdata[15:8] == 8'h00)
        else $error("counter upper byte set");
    status_read_a: assert property (rd_stat
        |=> reg_rdata[8:0] == 9'h000
        && reg_rdata[15] == $past(host_irq_status))
        else $error("status read wrong");
    pcs_reserved_a: assert property (reg_rd && reg_addr == 8'hD8
        |=> (reg_rdata & 16'hE0DB) == 16'h0000) else $error("pcs reserved set");
    test_irq_a: assert property (reg_rd && test_on
        |=> host_irq_status) else $error("test interrupt missing");
    read_clear_a: assert property (rd_stat && !test_on && !ev_en
        |=> !host_irq_status) else $error("pending not cleared by read");
    no_event_a: assert property (!test_on && !ev_en
        && !host_irq_status |=> !host_irq_status)
        else $error("interrupt while disabled");
    pending_hold_a: assert property (host_irq_status && !rd_stat
        |=> host_irq_status) else $error("pending dropped without read");
    pcs_follow_a: assert property (wr_pcs
        |=> ##1 pcs_view == ($past(pcs_shadow) & 16'h1F04))
        else $error("pcs outputs do not follow write");
    fast_or_a: assert property (mac_fast_link_force
        |=> pcs_ctrl.fast_link_force) else $error("fast link force lost");

    cover property (rd_stat && host_irq_status);
    cover property (reg_rd && test_on);
    cover property (wr_pcs);
endmodule

bind pics_bank pics_bank_asserts pics_bank_asserts_i (
    .clk(clk), .rst_n(rst_n), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
    .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
    .link_change(link_change), .jabber_event(jabber_event),
    .remote_fault(remote_fault), .autoneg_done(autoneg_done),
    .false_carrier(false_carrier), .carrier_valid(carrier_valid),
    .symbol_error(symbol_error), .collision(collision),
    .mac_fast_link_force(mac_fast_link_force),
    .host_irq_status(host_irq_status), .pcs_ctrl(pcs_ctrl));
`default_nettype wire

// File: test_pics_bank.sv
// self-checking bench for the interrupt, counter and pcs config bank
`timescale 1ns/1ns
`default_nettype none
`define CHK(got, exp) begin n_checks++; if ((got) !== (exp)) begin \
    fail_count++; $display("[FAIL] %0t got %h expected %h", $time, \
    got, exp); end end
module test_pics_bank;
    logic                clk = 1'b0;
    logic                rst_n = 1'b0;
    logic [7:0]          reg_addr = 8'h00;
    logic [15:0]         reg_wdata = 16'h0000;
    logic                reg_wr = 1'b0, reg_rd = 1'b0, false_carrier = 1'b0;
    logic                link_change = 1'b0, jabber_event = 1'b0;
    logic                remote_fault = 1'b0, autoneg_done = 1'b0;
    logic                carrier_valid = 1'b0, symbol_error = 1'b0;
    logic                collision = 1'b0, mac_fast_link_force = 1'b0;
    logic [15:0]         reg_rdata;
    logic                host_irq_status;
    pics_pkg::pics_pcs_t pcs_ctrl;
    int                  fail_count = 0;
    int                  n_checks = 0;
    int                  cycles = 0;

    pics_bank pics_bank_i (
        .clk(clk), .rst_n(rst_n), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
        .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
        .link_change(link_change), .jabber_event(jabber_event),
        .remote_fault(remote_fault), .autoneg_done(autoneg_done),
        .false_carrier(false_carrier), .carrier_valid(carrier_valid),
        .symbol_error(symbol_error), .collision(collision),
        .mac_fast_link_force(mac_fast_link_force),
        .host_irq_status(host_irq_status), .pcs_ctrl(pcs_ctrl));

    always #25 clk = ~clk;

    task automatic wrap_up();
        if (fail_count == 0 && n_checks > 0)
            $display("Finished cleanly");
        else
            $display("Finished with errors");
        $finish;
    endtask

    task automatic wt(input int n);
        repeat (n) @(posedge clk);
        #1;
    endtask

    task automatic wr(input logic [7:0] a, input logic [15:0] d);
        @(posedge clk);
        reg_addr <= a;
        reg_wdata <= d;
        reg_wr <= 1'b1;
        @(posedge clk);
        reg_wr <= 1'b0;
    endtask

    // the reply stands for one cycle only, so sample just after it lands
    task automatic rd(input logic [7:0] a, input logic [15:0] e);
        @(posedge clk);
        reg_addr <= a;
        reg_rd <= 1'b1;
        @(posedge clk);
        reg_rd <= 1'b0;
        #1;
        `CHK(reg_rdata, e)
    endtask

    // several bad symbols in one carrier must still count once
    task automatic carrier(input logic err, input logic col);
        @(posedge clk);
        carrier_valid <= 1'b1;
        symbol_error <= err;
        collision <= col;
        repeat (3) @(posedge clk);
        {carrier_valid, symbol_error, collision} <= 3'b000;
        repeat (3) @(posedge clk);
    endtask

    task automatic fcar(input int n);
        @(posedge clk);
        false_carrier <= 1'b1;
        repeat (n) @(posedge clk);
        false_carrier <= 1'b0;
    endtask

    always @(posedge clk) begin
        cycles++;
        if (cycles == 3000) begin
            fail_count++;
            wrap_up();
        end
    end

    initial begin
        repeat (6) @(posedge clk);
        rst_n <= 1'b1;
        rd(8'hC4, 16'h0000);
        rd(8'hC8, 16'h0000);
        rd(8'hD0, 16'h0000);
        rd(8'hD4, 16'h0000);
        rd(8'hD8, 16'h0100);
        rd(8'hCC, 16'h0000);
        `CHK(pcs_ctrl, 7'h04)
        wr(8'hC4, 16'hFFFF);
        rd(8'hC4, 16'h0003);
        wr(8'hC4, 16'h0000);
        rd(8'hC8, 16'h8000);
        rd(8'hC8, 16'h0000);
        wr(8'hD8, 16'hFFFF);
        rd(8'hD8, 16'h1F24);
        `CHK(pcs_ctrl, 7'h7F)
        wr(8'hD8, 16'h0000);
        mac_fast_link_force <= 1'b1;
        wt(2);
        `CHK(pcs_ctrl, 7'h02)
        mac_fast_link_force <= 1'b0;
        wr(8'hD0, 16'h00FD);
        fcar(4);
        rd(8'hD0, 16'h00FF);
        rd(8'hD0, 16'h0000);
        carrier(1'b1, 1'b0);
        carrier(1'b1, 1'b1);
        carrier(1'b0, 1'b0);
        rd(8'hD4, 16'h0001);
        wr(8'hD4, 16'h00FF);
        carrier(1'b1, 1'b0);
        rd(8'hD4, 16'h00FF);
        rd(8'hD4, 16'h0000);
        wr(8'hC8, 16'h0000);
        autoneg_done <= 1'b1;
        wt(4);
        `CHK(host_irq_status, 1'b0)
        autoneg_done <= 1'b0;
        wr(8'hC8, 16'h7E00);
        wr(8'hC4, 16'h0002);
        autoneg_done <= 1'b1;
        wt(4);
        `CHK(host_irq_status, 1'b0)
        autoneg_done <= 1'b0;
        for (int i = 0; i < 6; i++) begin
            wr(8'hC8, 16'h7E00 & ~(16'h0200 << i));
            case (i)
                0: begin
                    wr(8'hD4, 16'h007F);
                    carrier(1'b1, 1'b0);
                end
                1: begin
                    wr(8'hD0, 16'h007F);
                    fcar(1);
                end
                2: autoneg_done <= 1'b1;
                3: remote_fault <= 1'b1;
                4: jabber_event <= 1'b1;
                default: link_change <= 1'b1;
            endcase
            wt(6);
            `CHK(host_irq_status, 1'b1)
            rd(8'hC8, 16'hFE00 & ~(16'h0200 << i));
            `CHK(host_irq_status, 1'b0)
            {autoneg_done, remote_fault, jabber_event} <= 3'b000;
        end
        wr(8'hC4, 16'h0001);
        rd(8'hD8, 16'h0000);
        `CHK(host_irq_status, 1'b1)
        rd(8'hC8, 16'hBE00);
        `CHK(host_irq_status, 1'b1)
        wr(8'hC4, 16'h0000);
        rd(8'hC8, 16'hBE00);
        rd(8'hC8, 16'h3E00);
        `CHK(host_irq_status, 1'b0)
        wrap_up();
    end
endmodule
`default_nettype wire
